// ===== core/nvm_device.sv
// memory device end: address decode, protection, register space and write cycle
// How it works
// - block and word form 11-bit byte address
// - block 000 registers, 010 config, 011 eeprom
// - 32 pages of 16 bytes, half each
// - page 14 holds protection settings
// - master programs page 14 with lock set
// - protection page applied only after reset
// - page 15 readable, never writable
// - bits only rise; program once per erase (the device ORs repeat writes into the page)
// - master writes eeprom one page per command
// - master uses 011 eeprom, 010 config
// - all 16 eeprom pages user accessible
// - write protect register at E2 block 000
// - protect register read randomly, single-byte written
// - bit 2 enables eeprom protection
// - bits 1:0 pick protected upper quarters
// - select bits ignored while enable clear
// - lock bit freezes protect registers
// - control byte: code, block, read bit
// - erase register starts page erase at stop
// - page write completes within 20 ms
`timescale 1ns/100ps
module nvm_device #(
	parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link to the master
	nvm_link_if.dev link,
	// state for the user
	output logic [7:0] writeProtect,
	output logic protectLocked,
	output logic cycleBusy
);
	localparam int CW = $clog2(WRITE_CYCLES + 1);
	localparam logic [CW-1:0] LAST_CYCLE = CW'(WRITE_CYCLES - 1);

	typedef enum {PH_IDLE, PH_CTRL, PH_WORD, PH_DATA, PH_READ, PH_SKIP} phase_e;
	typedef enum {OP_NONE, OP_PAGE, OP_ERASE} op_e;

	phase_e phase, next_phase;
	op_e op, next_op;
	logic [2:0] block, next_block;
	logic [7:0] word, next_word;
	logic [4:0] count, next_count;
	logic [127:0] pageBuf, next_pageBuf;
	logic [15:0] mask, next_mask;
	logic [7:0] firstByte, next_firstByte;
	logic [7:0] eeprom_write_protect, next_wpr;
	logic [7:0] register_space_protect, next_rpr;
	logic [7:0] config_space_protect, next_npr;
	logic lock, next_lock;
	logic pageLock, next_pageLock;
	logic [7:0] eraseReg, next_eraseReg;
	logic loadReq, next_loadReq;
	logic [4:0] opPage, next_opPage;
	logic [CW-1:0] timer, next_timer;
	logic [7:0] readData, next_readData;
	logic readValid, next_readValid;
	logic ackNow;
	logic doWrite;
	logic doErase;
	logic [3:0] bufIdx;
	logic [7:0] arrByte;
	logic [23:0] protBytes;
	logic [7:0] regRead;

	// page is closed to writes and erases
	function automatic logic pageBlocked(input logic [4:0] pg, input logic [7:0] wp, input logic pl);
		if (pg[4]) begin
			// upper quarters from the top: 00 one, 01 two, 10 three, 11 all
			return wp[nvm_pkg::WPR_EN_BIT] && (pg[3:2] >= ~wp[nvm_pkg::WPR_SEL_LSB +: 2]);
		end
		return (pg == nvm_pkg::SERVICE_PAGE) || (pg == nvm_pkg::PROT_PAGE && pl);
	endfunction

	nvm_array u_array (
		.clk(clk),
		.sys_rst(sys_rst),
		.pageWrite(doWrite),
		.pageErase(doErase),
		.page(opPage),
		.pageData(pageBuf),
		.byteMask(mask),
		.readIdx({block[0], word}),
		.readByte(arrByte),
		.protBytes(protBytes)
	);

	assign bufIdx = word[3:0] + count[3:0];

	always_comb begin
		unique case (word)
			nvm_pkg::WPR_ADDR: regRead = eeprom_write_protect;
			nvm_pkg::ERASE_ADDR: regRead = eraseReg;
			nvm_pkg::LOCK_ADDR: regRead = 8'(lock) << nvm_pkg::LOCK_BIT;
			nvm_pkg::RPR_ADDR: regRead = register_space_protect;
			nvm_pkg::NPR_ADDR: regRead = config_space_protect;
			default: regRead = nvm_pkg::REG_RESET;
		endcase
	end

	always_comb begin
		next_phase = phase;
		next_op = op;
		next_block = block;
		next_word = word;
		next_count = count;
		next_pageBuf = pageBuf;
		next_mask = mask;
		next_firstByte = firstByte;
		next_wpr = eeprom_write_protect;
		next_rpr = register_space_protect;
		next_npr = config_space_protect;
		next_lock = lock;
		next_pageLock = pageLock;
		next_eraseReg = eraseReg;
		next_loadReq = 1'b0;
		next_opPage = opPage;
		next_timer = timer;
		next_readData = readData;
		next_readValid = 1'b0;
		ackNow = 1'b0;
		doWrite = 1'b0;
		doErase = 1'b0;
		// reload protection state from the array after any reset
		if (loadReq) begin
			next_wpr = protBytes[nvm_pkg::PROT_BYTE_WPR*8 +: 8] & 8'h07;
			next_rpr = protBytes[nvm_pkg::PROT_BYTE_RPR*8 +: 8];
			next_npr = protBytes[nvm_pkg::PROT_BYTE_NPR*8 +: 8];
			next_lock = protBytes[nvm_pkg::PROT_BYTE_WPR*8 + nvm_pkg::PROT_LOCK_BIT];
			next_pageLock = protBytes[nvm_pkg::PROT_BYTE_WPR*8 + nvm_pkg::PAGE_LOCK_BIT];
		end
		unique case (phase)
			PH_IDLE, PH_SKIP: begin
			end
			PH_CTRL: begin
				if (link.byteValid) begin
					// nvm blocks refuse control bytes while a cycle runs
					ackNow = link.byteData[7:nvm_pkg::CTRL_CODE_LSB] == nvm_pkg::CTRL_CODE
						&& !(op != OP_NONE && link.byteData[3:2] == 2'b01);
					next_block = link.byteData[nvm_pkg::CTRL_BLOCK_LSB +: 3];
					if (!ackNow) begin
						next_phase = PH_SKIP;
					end else if (link.byteData[nvm_pkg::CTRL_READ_BIT]) begin
						next_phase = PH_READ;
					end else begin
						next_phase = PH_WORD;
					end
				end
			end
			PH_WORD: begin
				if (link.byteValid) begin
					ackNow = 1'b1;
					next_word = link.byteData;
					next_count = 5'h00;
					if (op == OP_NONE) begin
						next_mask = 16'h0000;
					end
					next_phase = PH_DATA;
				end
			end
			PH_DATA: begin
				if (link.byteValid) begin
					ackNow = 1'b1;
					if (count == 5'h00) begin
						next_firstByte = link.byteData;
					end
					if (op == OP_NONE) begin
						next_pageBuf[{bufIdx, 3'h0} +: 8] = link.byteData;
						next_mask[bufIdx] = 1'b1;
					end
					if (count != 5'h1F) begin
						next_count = count + 5'h01;
					end
				end
			end
			PH_READ: begin
				if (link.readStrobe) begin
					unique case (block)
						nvm_pkg::BLK_REG: next_readData = regRead;
						nvm_pkg::BLK_CFG, nvm_pkg::BLK_EE:
							next_readData = ({block[0], word[7:4]} == nvm_pkg::SERVICE_PAGE)
								? nvm_pkg::SERVICE_DATA : arrByte;
						default: next_readData = nvm_pkg::ERASED_BYTE;
					endcase
					next_readValid = 1'b1;
					next_word = word + 8'h01;
				end
			end
		endcase
		// stop ends the frame and launches whatever it carried
		if (link.frameStop) begin
			next_phase = PH_IDLE;
			if (phase == PH_DATA && block == nvm_pkg::BLK_REG && count == 5'h01) begin
				unique case (word)
					nvm_pkg::WPR_ADDR: if (!lock) next_wpr = firstByte & 8'h07;
					nvm_pkg::RPR_ADDR: if (!lock) next_rpr = firstByte;
					nvm_pkg::NPR_ADDR: if (!lock) next_npr = firstByte;
					nvm_pkg::ERASE_ADDR: begin
						if (firstByte[nvm_pkg::ERASE_GO_BIT] && op == OP_NONE
							&& !pageBlocked(firstByte[4:0], eeprom_write_protect, pageLock)) begin
							next_eraseReg = firstByte & 8'h9F;
							next_opPage = firstByte[4:0];
							next_op = OP_ERASE;
							next_timer = '0;
						end
					end
					nvm_pkg::SOFT_RESET_ADDR: next_loadReq = firstByte[nvm_pkg::SOFT_RESET_BIT];
					default: begin
					end
				endcase
			end
			if (phase == PH_DATA && block[2:1] == 2'b01 && mask != 16'h0000 && op == OP_NONE
				&& !pageBlocked({block[0], word[7:4]}, eeprom_write_protect, pageLock)) begin
				next_opPage = {block[0], word[7:4]};
				next_op = OP_PAGE;
				next_timer = '0;
			end
		end
		if (link.frameStart) begin
			next_phase = PH_CTRL;
		end
		// internally timed cycle, commits at its last count
		if (op != OP_NONE) begin
			if (timer == LAST_CYCLE) begin
				doWrite = op == OP_PAGE;
				doErase = op == OP_ERASE;
				next_eraseReg = 8'h00;
				next_op = OP_NONE;
			end else begin
				next_timer = timer + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= PH_IDLE;
			op <= OP_NONE;
			block <= nvm_pkg::BLK_REG;
			word <= 8'h00;
			count <= 5'h00;
			pageBuf <= '0;
			mask <= 16'h0000;
			firstByte <= 8'h00;
			eeprom_write_protect <= nvm_pkg::WPR_RESET;
			register_space_protect <= nvm_pkg::REG_RESET;
			config_space_protect <= nvm_pkg::REG_RESET;
			lock <= 1'b0;
			pageLock <= 1'b0;
			eraseReg <= 8'h00;
			loadReq <= 1'b1;
			opPage <= 5'h00;
			timer <= '0;
			readData <= 8'h00;
			readValid <= 1'b0;
		end else begin
			phase <= next_phase;
			op <= next_op;
			block <= next_block;
			word <= next_word;
			count <= next_count;
			pageBuf <= next_pageBuf;
			mask <= next_mask;
			firstByte <= next_firstByte;
			eeprom_write_protect <= next_wpr;
			register_space_protect <= next_rpr;
			config_space_protect <= next_npr;
			lock <= next_lock;
			pageLock <= next_pageLock;
			eraseReg <= next_eraseReg;
			loadReq <= next_loadReq;
			opPage <= next_opPage;
			timer <= next_timer;
			readData <= next_readData;
			readValid <= next_readValid;
		end
	end

	assign link.ack = ackNow;
	assign link.readData = readData;
	assign link.readValid = readValid;
	assign link.busy = op != OP_NONE;
	assign writeProtect = eeprom_write_protect;
	assign protectLocked = lock;
	assign cycleBusy = op != OP_NONE;
endmodule

// ===== core/nvm_pkg.sv
// constants shared by both ends of the memory programming link
package nvm_pkg;
	// control byte
	localparam logic [3:0] CTRL_CODE = 4'h1;
	localparam int CTRL_CODE_LSB = 4;
	localparam int CTRL_BLOCK_LSB = 1;
	localparam int CTRL_READ_BIT = 0;
	// block codes
	localparam logic [2:0] BLK_REG = 3'h0;
	localparam logic [2:0] BLK_UNUSED = 3'h1;
	localparam logic [2:0] BLK_CFG = 3'h2;
	localparam logic [2:0] BLK_EE = 3'h3;
	localparam int ADDR_BITS = 11;
	// array shape
	localparam int PAGES = 32;
	localparam int PAGE_BYTES = 16;
	localparam int CFG_PAGES = 16;
	localparam logic [4:0] PROT_PAGE = 5'h0E;
	localparam logic [4:0] SERVICE_PAGE = 5'h0F;
	localparam logic [7:0] ERASED_BYTE = 8'h00;
	// service page contents, arbitrary value
	localparam logic [7:0] SERVICE_DATA = 8'hA5;
	// protection page byte layout
	localparam int PROT_BYTE_WPR = 0;
	localparam int PROT_BYTE_RPR = 1;
	localparam int PROT_BYTE_NPR = 2;
	localparam int PROT_LOCK_BIT = 6;
	localparam int PAGE_LOCK_BIT = 7;
	// volatile register space
	localparam logic [7:0] WPR_ADDR = 8'hE2;
	localparam logic [7:0] ERASE_ADDR = 8'hE3;
	localparam logic [7:0] LOCK_ADDR = 8'hE4;
	localparam logic [7:0] RPR_ADDR = 8'hE5;
	localparam logic [7:0] NPR_ADDR = 8'hE6;
	localparam logic [7:0] SOFT_RESET_ADDR = 8'hF5;
	localparam int LOCK_REG_BIT = 1824;
	localparam int LOCK_BIT = LOCK_REG_BIT % 8;
	localparam int WPR_EN_BIT = 2;
	localparam int WPR_SEL_LSB = 0;
	localparam int ERASE_GO_BIT = 7;
	localparam int SOFT_RESET_BIT = 0;
	localparam logic [7:0] WPR_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int WRITE_TIME_MS = 20;
	// clock cycles in the longest write or erase cycle
	localparam int WRITE_CYCLES = WRITE_TIME_MS * CLK_MHZ * 1000;
endpackage

// ===== core/nvm_link_if.sv
// byte level command link between programming master and memory device
`timescale 1ns/100ps
interface nvm_link_if;
	logic frameStart;
	logic frameStop;
	logic byteValid;
	logic [7:0] byteData;
	logic readStrobe;
	logic ack;
	logic [7:0] readData;
	logic readValid;
	logic busy;
	modport dev (
		input frameStart,
		input frameStop,
		input byteValid,
		input byteData,
		input readStrobe,
		output ack,
		output readData,
		output readValid,
		output busy
	);
	modport host (
		output frameStart,
		output frameStop,
		output byteValid,
		output byteData,
		output readStrobe,
		input ack,
		input readData,
		input readValid,
		input busy
	);
endinterface

// ===== core/nvm_array.sv
// page organised non-volatile array with or-programming and page erase
`timescale 1ns/100ps
module nvm_array (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// page commit
	input wire logic pageWrite,
	input wire logic pageErase,
	input wire logic [4:0] page,
	input wire logic [127:0] pageData,
	input wire logic [15:0] byteMask,
	// read
	input wire logic [8:0] readIdx,
	output logic [7:0] readByte,
	output logic [23:0] protBytes
);
	logic [7:0] mem [0:511];

	for (genvar i = 0; i < nvm_pkg::PAGES * nvm_pkg::PAGE_BYTES; i++) begin : g_cell
		localparam logic [4:0] PG = 5'(i / nvm_pkg::PAGE_BYTES);
		localparam int BY = i % nvm_pkg::PAGE_BYTES;
		logic [7:0] next_cell;
		always_comb begin
			next_cell = mem[i];
			if (pageErase && page == PG) begin
				next_cell = nvm_pkg::ERASED_BYTE;
			end else if (pageWrite && page == PG && byteMask[BY]) begin
				next_cell = mem[i] | pageData[BY*8 +: 8];
			end
		end
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				mem[i] <= nvm_pkg::ERASED_BYTE;
			end else begin
				mem[i] <= next_cell;
			end
		end
	end

	assign readByte = mem[readIdx];
	assign protBytes = {mem[{nvm_pkg::PROT_PAGE, 4'h2}], mem[{nvm_pkg::PROT_PAGE, 4'h1}], mem[{nvm_pkg::PROT_PAGE, 4'h0}]};
endmodule

// ===== core/nvm_host.sv
// programming master end: turns user commands into link frames
`timescale 1ns/100ps
module nvm_host (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link to the device
	nvm_link_if.host link,
	// user command
	input wire logic cmdValid,
	input wire logic cmdRead,
	input wire logic [2:0] cmdBlock,
	input wire logic [7:0] cmdWord,
	input wire logic [4:0] cmdCount,
	input wire logic [127:0] cmdData,
	output logic cmdReady,
	// user answer
	output logic [7:0] rdByte,
	output logic rdByteValid,
	output logic cmdDone,
	output logic cmdNack
);
	typedef enum {H_IDLE, H_START, H_CTRL, H_WORD, H_DATA, H_RSTART, H_RCTRL, H_RREQ, H_RWAIT, H_STOP} state_e;

	state_e state, next_state;
	logic read, next_read;
	logic [2:0] blk, next_blk;
	logic [7:0] wordAddr, next_wordAddr;
	logic [3:0] last, next_last;
	logic [127:0] data, next_data;
	logic [3:0] idx, next_idx;
	logic [7:0] outByte, next_outByte;
	logic [7:0] rdByteQ, next_rdByte;
	logic rdValidQ, next_rdValid;
	logic doneQ, next_done;
	logic nackQ, next_nack;

	always_comb begin
		next_state = state;
		next_read = read;
		next_blk = blk;
		next_wordAddr = wordAddr;
		next_last = last;
		next_data = data;
		next_idx = idx;
		next_outByte = outByte;
		next_rdByte = rdByteQ;
		next_rdValid = 1'b0;
		next_done = 1'b0;
		next_nack = nackQ;
		unique case (state)
			H_IDLE: begin
				if (cmdValid) begin
					next_read = cmdRead;
					next_blk = cmdBlock;
					next_wordAddr = cmdWord;
					next_last = (cmdCount == 5'h00) ? 4'h0 : 4'(cmdCount - 5'h01);
					next_data = cmdData;
					next_nack = 1'b0;
					next_outByte = {nvm_pkg::CTRL_CODE, cmdBlock, 1'b0};
					next_state = H_START;
				end
			end
			H_START: next_state = H_CTRL;
			H_CTRL: begin
				if (link.ack) begin
					next_outByte = wordAddr;
					next_state = H_WORD;
				end else begin
					next_nack = 1'b1;
					next_state = H_STOP;
				end
			end
			H_WORD: begin
				next_idx = 4'h0;
				if (read) begin
					next_outByte = {nvm_pkg::CTRL_CODE, blk, 1'b1};
					next_state = H_RSTART;
				end else begin
					// each byte is sent once per command, never rewritten
					next_outByte = data[7:0];
					next_state = H_DATA;
				end
			end
			H_DATA: begin
				if (idx == last) begin
					next_state = H_STOP;
				end else begin
					next_idx = idx + 4'h1;
					next_outByte = data[{next_idx, 3'h0} +: 8];
				end
			end
			H_RSTART: next_state = H_RCTRL;
			H_RCTRL: begin
				if (link.ack) begin
					next_state = H_RREQ;
				end else begin
					next_nack = 1'b1;
					next_state = H_STOP;
				end
			end
			H_RREQ: next_state = H_RWAIT;
			H_RWAIT: begin
				if (link.readValid) begin
					next_rdByte = link.readData;
					next_rdValid = 1'b1;
					if (idx == last) begin
						next_state = H_STOP;
					end else begin
						next_idx = idx + 4'h1;
						next_state = H_RREQ;
					end
				end
			end
			H_STOP: begin
				next_done = 1'b1;
				next_state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= H_IDLE;
			read <= 1'b0;
			blk <= nvm_pkg::BLK_REG;
			wordAddr <= 8'h00;
			last <= 4'h0;
			data <= '0;
			idx <= 4'h0;
			outByte <= 8'h00;
			rdByteQ <= 8'h00;
			rdValidQ <= 1'b0;
			doneQ <= 1'b0;
			nackQ <= 1'b0;
		end else begin
			state <= next_state;
			read <= next_read;
			blk <= next_blk;
			wordAddr <= next_wordAddr;
			last <= next_last;
			data <= next_data;
			idx <= next_idx;
			outByte <= next_outByte;
			rdByteQ <= next_rdByte;
			rdValidQ <= next_rdValid;
			doneQ <= next_done;
			nackQ <= next_nack;
		end
	end

	assign link.frameStart = state == H_START || state == H_RSTART;
	assign link.frameStop = state == H_STOP;
	assign link.byteValid = state == H_CTRL || state == H_WORD || state == H_DATA || state == H_RCTRL;
	assign link.byteData = outByte;
	assign link.readStrobe = state == H_RREQ;
	assign cmdReady = state == H_IDLE;
	assign rdByte = rdByteQ;
	assign rdByteValid = rdValidQ;
	assign cmdDone = doneQ;
	assign cmdNack = nackQ;
endmodule

// ===== tb/nvm_link_props.sv
// link checker: control acks, read answers, write cycle length
`timescale 1ns/100ps
module nvm_link_props #(
	parameter int WRITE_CYCLES = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// host to device
	input wire logic frameStart,
	input wire logic frameStop,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic readStrobe,
	// device to host
	input wire logic ack,
	input wire logic [7:0] readData,
	input wire logic readValid,
	input wire logic busy
);
	logic ctrlPhase;
	logic frameOk;
	int busyCnt;
	// control byte position, frame acceptance, busy length
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlPhase <= 1'b0;
			frameOk <= 1'b0;
			busyCnt <= 0;
		end else begin
			ctrlPhase <= frameStart | (ctrlPhase & ~byteValid);
			if (frameStart)
				frameOk <= 1'b0;
			else if (ctrlPhase && byteValid)
				frameOk <= ack;
			busyCnt <= busy ? busyCnt + 1 : 0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	ctrl_ack_a: assert property (byteValid && ctrlPhase |->
		ack == (byteData[7:4] == nvm_pkg::CTRL_CODE && !(busy && byteData[3:2] == 2'b01)))
		else $error("control byte ack wrong");
	data_ack_a: assert property (byteValid && !ctrlPhase && frameOk |-> ack)
		else $error("data byte not acked");
	read_answer_a: assert property (readStrobe |=> readValid)
		else $error("read strobe not answered");
	read_cause_a: assert property (readValid |-> $past(readStrobe))
		else $error("read answer without strobe");
	read_hold_a: assert property ($changed(readData) |-> readValid)
		else $error("read data moved without answer");
	busy_start_a: assert property ($rose(busy) |-> $past(frameStop))
		else $error("write cycle not started by stop");
	busy_hold_a: assert property ($rose(busy) |-> busy [*8])
		else $error("write cycle ended early");
	busy_len_a: assert property ($fell(busy) |-> busyCnt == WRITE_CYCLES)
		else $error("write cycle length wrong");
	busy_max_a: assert property (busyCnt <= WRITE_CYCLES)
		else $error("write cycle overran");
	frame_excl_a: assert property (!(frameStart && frameStop))
		else $error("start and stop together");
	cover property ($rose(busy));
	cover property (readValid);
	cover property (byteValid && ctrlPhase && !ack);
endmodule

// ===== tb/nvm_address_map_protection_tb_top.sv
// testbench: host and device joined by the link, driven from the host user port
`timescale 1ns/100ps
module nvm_address_map_protection_tb_top;
	localparam int WC = 12;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmdValid = 1'b0;
	logic cmdRead = 1'b0;
	logic [2:0] cmdBlock = 3'h0;
	logic [7:0] cmdWord = 8'h00;
	logic [4:0] cmdCount = 5'h01;
	logic [127:0] cmdData = 128'h0;
	logic cmdReady, rdByteValid, cmdDone, cmdNack, protectLocked, cycleBusy;
	logic [7:0] rdByte;
	logic [7:0] writeProtect;
	logic [7:0] rd [0:15];
	logic [127:0] pat;
	logic nack;
	int failures = 0;
	int tests_run = 0;
	int p;
	nvm_link_if i_nvm_link_if();
	nvm_device #(.WRITE_CYCLES(WC)) i_nvm_device (.clk(clk), .sys_rst(sys_rst), .link(i_nvm_link_if.dev),
		.writeProtect(writeProtect), .protectLocked(protectLocked), .cycleBusy(cycleBusy));
	nvm_host i_nvm_host (.clk(clk), .sys_rst(sys_rst), .link(i_nvm_link_if.host), .cmdValid(cmdValid),
		.cmdRead(cmdRead), .cmdBlock(cmdBlock), .cmdWord(cmdWord), .cmdCount(cmdCount), .cmdData(cmdData),
		.cmdReady(cmdReady), .rdByte(rdByte), .rdByteValid(rdByteValid), .cmdDone(cmdDone), .cmdNack(cmdNack));
	nvm_link_props #(.WRITE_CYCLES(WC)) i_nvm_link_props (.clk(clk), .sys_rst(sys_rst),
		.frameStart(i_nvm_link_if.frameStart), .frameStop(i_nvm_link_if.frameStop),
		.byteValid(i_nvm_link_if.byteValid), .byteData(i_nvm_link_if.byteData),
		.readStrobe(i_nvm_link_if.readStrobe), .ack(i_nvm_link_if.ack), .readData(i_nvm_link_if.readData),
		.readValid(i_nvm_link_if.readValid), .busy(i_nvm_link_if.busy));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one whole command through the host; read bytes land in rd
	task automatic cmd(input logic r, input logic [2:0] blk, input logic [7:0] wd, input logic [4:0] cnt,
		input logic [127:0] dat);
		int n;
		int k;
		n = 0;
		k = 0;
		@(negedge clk);
		while (cmdReady !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
		cmdValid = 1'b1;
		cmdRead = r;
		cmdBlock = blk;
		cmdWord = wd;
		cmdCount = cnt;
		cmdData = dat;
		@(negedge clk);
		cmdValid = 1'b0;
		while (k < 200) begin
			if (rdByteValid === 1'b1 && n < 16) begin
				rd[n] = rdByte;
				n++;
			end
			if (cmdDone === 1'b1)
				break;
			@(negedge clk);
			k++;
		end
		nack = cmdNack;
		if (k >= 200) begin
			failures++;
			give_verdict();
		end
	endtask
	task automatic wr1(input logic [2:0] blk, input logic [7:0] wd, input logic [7:0] b);
		cmd(1'b0, blk, wd, 5'h01, {120'h0, b});
	endtask
	task automatic rd1(input logic [2:0] blk, input logic [7:0] wd);
		cmd(1'b1, blk, wd, 5'h01, 128'h0);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while ((i_nvm_link_if.busy !== 1'b0 || cycleBusy !== 1'b0) && k < WC + 20) begin
			@(negedge clk);
			k++;
		end
		if (k >= WC + 20) begin
			failures++;
			give_verdict();
		end
	endtask
	initial begin
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		rd1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR);
		check("wpr reset", rd[0], nvm_pkg::WPR_RESET);
		check("wpr port", writeProtect, nvm_pkg::WPR_RESET);
		for (int k = 0; k < 16; k++)
			pat[8*k +: 8] = 8'(8'h10 + k);
		cmd(1'b0, nvm_pkg::BLK_EE, 8'h50, 5'h10, pat);
		rd1(nvm_pkg::BLK_EE, 8'h50);
		check("nack busy", {7'h00, nack}, 8'h01);
		rd1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR);
		check("reg in busy", {7'h00, nack}, 8'h00);
		wait_idle();
		cmd(1'b1, nvm_pkg::BLK_EE, 8'h50, 5'h10, 128'h0);
		for (int k = 0; k < 16; k++)
			check("page byte", rd[k], 8'(8'h10 + k));
		wr1(nvm_pkg::BLK_EE, 8'h50, 8'h0F);
		wait_idle();
		rd1(nvm_pkg::BLK_EE, 8'h50);
		check("or program", rd[0], 8'h1F);
		for (int s = 0; s < 4; s++) begin
			wr1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR, 8'(4 + s));
			rd1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR);
			check("wpr rd", rd[0], 8'(4 + s));
			p = 12 - 4 * s;
			wr1(nvm_pkg::BLK_EE, 8'(p * 16), 8'hFF);
			wait_idle();
			rd1(nvm_pkg::BLK_EE, 8'(p * 16));
			check("blocked", rd[0], nvm_pkg::ERASED_BYTE);
			if (s < 3) begin
				wr1(nvm_pkg::BLK_EE, 8'((p - 1) * 16), 8'hFF);
				wait_idle();
				rd1(nvm_pkg::BLK_EE, 8'((p - 1) * 16));
				check("open", rd[0], 8'hFF);
			end
		end
		wr1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR, 8'h03);
		wr1(nvm_pkg::BLK_EE, 8'hD0, 8'hFF);
		wait_idle();
		rd1(nvm_pkg::BLK_EE, 8'hD0);
		check("enable off", rd[0], 8'hFF);
		wr1(nvm_pkg::BLK_CFG, 8'hF0, 8'h5A);
		wait_idle();
		rd1(nvm_pkg::BLK_CFG, 8'hF0);
		check("service", rd[0], nvm_pkg::SERVICE_DATA);
		wr1(nvm_pkg::BLK_UNUSED, 8'h10, 8'hFF);
		wait_idle();
		rd1(nvm_pkg::BLK_UNUSED, 8'h10);
		check("unused 001", rd[0], 8'h00);
		rd1(3'h4, 8'h10);
		check("unused 1xx", rd[0], 8'h00);
		wr1(nvm_pkg::BLK_REG, nvm_pkg::ERASE_ADDR, {1'b1, 2'b00, 5'h15});
		wait_idle();
		rd1(nvm_pkg::BLK_EE, 8'h50);
		check("erased", rd[0], nvm_pkg::ERASED_BYTE);
		rd1(nvm_pkg::BLK_REG, nvm_pkg::ERASE_ADDR);
		check("erase clear", rd[0], 8'h00);
		wr1(nvm_pkg::BLK_CFG, 8'hE0, 8'hC5);
		wait_idle();
		check("no early load", writeProtect, 8'h03);
		check("no early lock", {7'h00, protectLocked}, 8'h00);
		wr1(nvm_pkg::BLK_REG, nvm_pkg::SOFT_RESET_ADDR, 8'h01);
		repeat (2) @(negedge clk);
		check("loaded wpr", writeProtect, 8'h05);
		check("locked", {7'h00, protectLocked}, 8'h01);
		wr1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR, 8'h00);
		rd1(nvm_pkg::BLK_REG, nvm_pkg::WPR_ADDR);
		check("frozen wpr", rd[0], 8'h05);
		rd1(nvm_pkg::BLK_REG, nvm_pkg::LOCK_ADDR);
		check("lock reg", rd[0], 8'h01);
		wr1(nvm_pkg::BLK_CFG, 8'hE1, 8'hFF);
		wait_idle();
		rd1(nvm_pkg::BLK_CFG, 8'hE1);
		check("page14 lock", rd[0], 8'h00);
		give_verdict();
	end
endmodule
